//--- common/t16cm_defines.svh
// register offsets, field positions and reset values of the 16-bit timer block
// assumes byte addresses on a 32-bit bus, one aligned word per register
`ifndef T16CM_DEFINES_SVH
`define T16CM_DEFINES_SVH

`define T16CM_NUM_MATCH 4
`define T16CM_NUM_CAP 3
`define T16CM_NUM_PIN 4

`define T16CM_OFF_CTRL 8'h00
`define T16CM_OFF_COUNT 8'h04
`define T16CM_OFF_PRESCALE 8'h08
`define T16CM_OFF_PRE_COUNT 8'h0c
`define T16CM_OFF_MATCH_CTRL 8'h10
`define T16CM_OFF_MATCH0 8'h14
`define T16CM_OFF_CAP_CTRL 8'h24
`define T16CM_OFF_CAP0 8'h28
`define T16CM_OFF_OUT_CTRL 8'h34
`define T16CM_OFF_EXT_OUT 8'h38
`define T16CM_OFF_IRQ_STATUS 8'h3c
`define T16CM_OFF_IRQ_MASK 8'h40
`define T16CM_OFF_CAP_ROUTE 8'h44
`define T16CM_OFF_OUT_ROUTE 8'h48

// control register fields
`define T16CM_CTRL_EN 0
`define T16CM_CTRL_CLR 1
`define T16CM_CTRL_MODE_LSB 2
`define T16CM_CTRL_SRC_LSB 4
`define T16CM_CTRL_W 6

// per match channel: 3 bits at 3*i
`define T16CM_MC_IRQ 0
`define T16CM_MC_RESET 1
`define T16CM_MC_STOP 2
// per capture channel: 3 bits at 3*c
`define T16CM_CC_RISE 0
`define T16CM_CC_FALL 1
`define T16CM_CC_IRQ 2
// capture routing: 8 bits per channel, pin mask low, and-mode at bit 7
`define T16CM_CR_AND 7
// irq status: match bits low, capture bits above
`define T16CM_IRQ_CAP_LSB 4
`define T16CM_IRQ_W 7

`define T16CM_RST_CTRL 6'h00
`define T16CM_RST_PRESCALE 16'h0000
`define T16CM_RST_MATCH 16'h0000
`define T16CM_RST_CAP_ROUTE 24'h040201
`define T16CM_RST_OUT_ROUTE 8'he4

`endif

//--- common/t16cm_pkg.sv
// types shared by the 16-bit timer block
// encodings follow the order of declaration, matching the register fields
package t16cm_pkg;
   typedef enum logic [1:0] {
      T16CM_MODE_TIMER,
      T16CM_MODE_RISE,
      T16CM_MODE_FALL,
      T16CM_MODE_BOTH
   } t16cm_mode_t;

   typedef enum logic [1:0] {
      T16CM_ACT_NONE,
      T16CM_ACT_LOW,
      T16CM_ACT_HIGH,
      T16CM_ACT_TOGGLE
   } t16cm_act_t;

   typedef enum logic {
      T16CM_BUS_IDLE,
      T16CM_BUS_ACK
   } t16cm_bus_t;
endpackage

//--- hw/t16cm_sync.sv
// three-flop input filter for asynchronous pins
// assumes pins are asynchronous to sys_clk; a change passes once flops two and three agree
`timescale 1ns/1ns
module t16cm_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // pins and filtered level
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   initial begin
      if (WIDTH < 1) begin
         $error("t16cm_sync: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // output follows only where the two later flops agree
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dout <= '0;
      end else begin
         dout <= (s2_reg & s3_reg) | (dout & (s2_reg | s3_reg));
      end
   end
endmodule

//--- hw/t16cm_top.sv
// 16-bit timer / event counter with four match and three capture channels
// assumes an avalon-mm master on sys_clk and asynchronous capture pins
// Operation
// RL1: count steps come from sys_clk ticks or from edges of a capture input.
// RL2: one 16-bit count register behind a programmable 16-bit prescaler.
// RL3: four 16-bit match registers compared with the count, optional interrupt.
// RL4: continuous match lets counting go on, interrupt only if enabled.
// RL5: stop match halts the counter at the match value, optional interrupt.
// RL6: reset match returns the count to zero, optional interrupt.
// RL7: enabled edge on a capture input copies the count, optional interrupt.
// RL8: external event pulses must last at least one clock period; the input filter drops levels held less than two clocks.
// RL9: capture lines not used as event clock still capture or interrupt.
// RL10: each match drives an output: low, high, toggle or unchanged.
// RL11: several pins may feed one capture (or/and) or mirror one match output.
// RL12: without stop or reset action the count wraps from maximum to zero.
`timescale 1ns/1ns
`include "t16cm_defines.svh"
module t16cm_top #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // capture pins and match output pins
   input wire logic [`T16CM_NUM_PIN-1:0] cap_pin,
   output logic [`T16CM_NUM_PIN-1:0] match_pin,
   // interrupt
   output logic irq
);
   import t16cm_pkg::*;

   localparam int NM = `T16CM_NUM_MATCH;
   localparam int NC = `T16CM_NUM_CAP;
   localparam int NP = `T16CM_NUM_PIN;

   initial begin
      if (CNT_W < 2 || CNT_W > 31) begin
         $error("t16cm_top: CNT_W must lie in 2..31");
      end
   end

   function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
      hits = (addr[7:2] == off[7:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_val,
                                         input logic [31:0] new_val,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = new_val[8*b +: 8];
         end
      end
      merge = res;
   endfunction

   // bus handshake: one wait state, then the access completes
   t16cm_bus_t bus_state_reg;
   logic req;
   logic wr_fire;
   logic [31:0] rd_word;

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & (bus_state_reg != T16CM_BUS_ACK);
   assign wr_fire = avs_write & (bus_state_reg == T16CM_BUS_ACK);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bus_state_reg <= T16CM_BUS_IDLE;
      end else begin
         case (bus_state_reg)
            T16CM_BUS_IDLE: begin
               if (req) begin
                  bus_state_reg <= T16CM_BUS_ACK;
               end
            end
            default: begin
               bus_state_reg <= T16CM_BUS_IDLE;
            end
         endcase
      end
   end

   // registers
   logic [`T16CM_CTRL_W-1:0] ctrl_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] prescale_reg;
   logic [CNT_W-1:0] pre_count_reg;
   logic [3*NM-1:0] match_ctrl_reg;
   logic [CNT_W-1:0] match_reg [NM];
   logic [3*NC-1:0] cap_ctrl_reg;
   logic [CNT_W-1:0] cap_reg [NC];
   logic [2*NM-1:0] out_ctrl_reg;
   logic [NM-1:0] ext_out_reg;
   logic [`T16CM_IRQ_W-1:0] irq_status_reg;
   logic [`T16CM_IRQ_W-1:0] irq_mask_reg;
   logic [8*NC-1:0] cap_route_reg;
   logic [2*NP-1:0] out_route_reg;

   logic [31:0] wdat;
   assign wdat = avs_writedata;

   // capture path: filter, combine pins, detect edges
   logic [NP-1:0] pin_lvl;
   logic [NC-1:0] cap_lvl;
   logic [NC-1:0] cap_prev_reg;
   logic [NC-1:0] cap_rise;
   logic [NC-1:0] cap_fall;
   logic [NC-1:0] cap_evt;

   t16cm_sync #(
      .WIDTH(NP)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .din(cap_pin),
      .dout(pin_lvl)
   );

   genvar gc;
   generate
      for (gc = 0; gc < NC; gc++) begin : g_cap
         logic [NP-1:0] mask;
         logic and_mode;
         assign mask = cap_route_reg[8*gc +: NP];
         assign and_mode = cap_route_reg[8*gc + `T16CM_CR_AND];
         // several pins merge into one capture input
         assign cap_lvl[gc] = and_mode ? ((&(pin_lvl | ~mask)) & (|mask))
                                       : (|(pin_lvl & mask)); // see RL11
         assign cap_rise[gc] = cap_lvl[gc] & ~cap_prev_reg[gc];
         assign cap_fall[gc] = ~cap_lvl[gc] & cap_prev_reg[gc];
         // captures stay live even on the line that clocks the counter
         assign cap_evt[gc] = (cap_rise[gc] & cap_ctrl_reg[3*gc + `T16CM_CC_RISE])
                            | (cap_fall[gc] & cap_ctrl_reg[3*gc + `T16CM_CC_FALL]); // see RL9

         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               cap_reg[gc] <= '0;
            end else if (cap_evt[gc]) begin
               cap_reg[gc] <= count_reg; // see RL7
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cap_prev_reg <= '0;
      end else begin
         cap_prev_reg <= cap_lvl;
      end
   end

   // count source and prescaler
   t16cm_mode_t mode;
   logic [1:0] src;
   logic ev_rise;
   logic ev_fall;
   logic ev_edge;
   logic run;
   logic tick;
   logic step;

   assign mode = t16cm_mode_t'(ctrl_reg[`T16CM_CTRL_MODE_LSB +: 2]);
   assign src = ctrl_reg[`T16CM_CTRL_SRC_LSB +: 2];
   assign run = ctrl_reg[`T16CM_CTRL_EN] & ~ctrl_reg[`T16CM_CTRL_CLR];

   // event edges come from the filtered level, so short glitches do not count
   always_comb begin
      ev_rise = 1'b0;
      ev_fall = 1'b0;
      if (src < 2'(NC)) begin
         ev_rise = cap_rise[src];
         ev_fall = cap_fall[src];
      end
      case (mode)
         T16CM_MODE_RISE: ev_edge = ev_rise;
         T16CM_MODE_FALL: ev_edge = ev_fall;
         T16CM_MODE_BOTH: ev_edge = ev_rise | ev_fall;
         default: ev_edge = 1'b0;
      endcase
   end

   assign tick = run & ((mode == T16CM_MODE_TIMER) | ev_edge); // see RL1, RL8
   assign step = tick & (pre_count_reg == prescale_reg); // see RL2

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pre_count_reg <= '0;
      end else if (ctrl_reg[`T16CM_CTRL_CLR]) begin
         pre_count_reg <= '0;
      end else if (step) begin
         pre_count_reg <= '0; // see RL2
      end else if (tick) begin
         pre_count_reg <= pre_count_reg + 1'b1;
      end
   end

   // match channels
   logic [NM-1:0] hit;
   logic [NM-1:0] hit_reset;
   logic [NM-1:0] hit_stop;
   logic [NM-1:0] hit_irq;

   genvar gm;
   generate
      for (gm = 0; gm < NM; gm++) begin : g_match
         assign hit[gm] = step & (count_reg == match_reg[gm]); // see RL3
         assign hit_reset[gm] = hit[gm] & match_ctrl_reg[3*gm + `T16CM_MC_RESET];
         assign hit_stop[gm] = hit[gm] & match_ctrl_reg[3*gm + `T16CM_MC_STOP];
         assign hit_irq[gm] = hit[gm] & match_ctrl_reg[3*gm + `T16CM_MC_IRQ];

         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               match_reg[gm] <= CNT_W'(`T16CM_RST_MATCH);
            end else if (wr_fire && hits(avs_address, `T16CM_OFF_MATCH0 + 8'(4*gm))) begin
               match_reg[gm] <= CNT_W'(merge(32'(match_reg[gm]), wdat, avs_byteenable));
            end
         end

         // hardware action on a hit overrides a software write in the same cycle
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               ext_out_reg[gm] <= 1'b0;
            end else if (hit[gm] && out_ctrl_reg[2*gm +: 2] != 2'(T16CM_ACT_NONE)) begin
               case (t16cm_act_t'(out_ctrl_reg[2*gm +: 2]))
                  T16CM_ACT_LOW: ext_out_reg[gm] <= 1'b0; // see RL10
                  T16CM_ACT_HIGH: ext_out_reg[gm] <= 1'b1; // see RL10
                  default: ext_out_reg[gm] <= ~ext_out_reg[gm]; // see RL10
               endcase
            end else if (wr_fire && hits(avs_address, `T16CM_OFF_EXT_OUT) && avs_byteenable[0]) begin
               ext_out_reg[gm] <= wdat[gm];
            end
         end
      end
   endgenerate

   // counter: reset match beats increment, plain increments wrap at the top
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (ctrl_reg[`T16CM_CTRL_CLR]) begin
         count_reg <= '0;
      end else if (step && |hit_reset) begin
         count_reg <= '0; // see RL6
      end else if (step && |hit_stop) begin
         count_reg <= count_reg; // see RL5
      end else if (step) begin
         count_reg <= count_reg + 1'b1; // see RL4, RL12
      end else if (wr_fire && hits(avs_address, `T16CM_OFF_COUNT)) begin
         count_reg <= CNT_W'(merge(32'(count_reg), wdat, avs_byteenable));
      end
   end

   // control: a stop hit clears the enable even against a write
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_reg <= `T16CM_RST_CTRL;
      end else begin
         if (wr_fire && hits(avs_address, `T16CM_OFF_CTRL) && avs_byteenable[0]) begin
            ctrl_reg <= wdat[`T16CM_CTRL_W-1:0];
         end
         if (|hit_stop) begin
            ctrl_reg[`T16CM_CTRL_EN] <= 1'b0; // see RL5
         end
      end
   end

   // plain configuration registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prescale_reg <= CNT_W'(`T16CM_RST_PRESCALE);
         match_ctrl_reg <= '0;
         cap_ctrl_reg <= '0;
         out_ctrl_reg <= '0;
         irq_mask_reg <= '0;
         cap_route_reg <= `T16CM_RST_CAP_ROUTE;
         out_route_reg <= `T16CM_RST_OUT_ROUTE;
      end else if (wr_fire) begin
         if (hits(avs_address, `T16CM_OFF_PRESCALE)) begin
            prescale_reg <= CNT_W'(merge(32'(prescale_reg), wdat, avs_byteenable));
         end else if (hits(avs_address, `T16CM_OFF_MATCH_CTRL)) begin
            match_ctrl_reg <= (3*NM)'(merge(32'(match_ctrl_reg), wdat, avs_byteenable));
         end else if (hits(avs_address, `T16CM_OFF_CAP_CTRL)) begin
            cap_ctrl_reg <= (3*NC)'(merge(32'(cap_ctrl_reg), wdat, avs_byteenable));
         end else if (hits(avs_address, `T16CM_OFF_OUT_CTRL)) begin
            out_ctrl_reg <= (2*NM)'(merge(32'(out_ctrl_reg), wdat, avs_byteenable));
         end else if (hits(avs_address, `T16CM_OFF_IRQ_MASK)) begin
            irq_mask_reg <= `T16CM_IRQ_W'(merge(32'(irq_mask_reg), wdat, avs_byteenable));
         end else if (hits(avs_address, `T16CM_OFF_CAP_ROUTE)) begin
            cap_route_reg <= (8*NC)'(merge(32'(cap_route_reg), wdat, avs_byteenable));
         end else if (hits(avs_address, `T16CM_OFF_OUT_ROUTE)) begin
            out_route_reg <= (2*NP)'(merge(32'(out_route_reg), wdat, avs_byteenable));
         end
      end
   end

   // interrupt status: new events win over a write-one-to-clear
   logic [`T16CM_IRQ_W-1:0] irq_set;
   logic [`T16CM_IRQ_W-1:0] irq_clr;
   logic [NC-1:0] cap_irq;

   generate
      for (gc = 0; gc < NC; gc++) begin : g_cirq
         assign cap_irq[gc] = cap_evt[gc] & cap_ctrl_reg[3*gc + `T16CM_CC_IRQ]; // see RL7, RL9
      end
   endgenerate

   assign irq_set = {cap_irq, hit_irq}; // see RL3
   assign irq_clr = (wr_fire && hits(avs_address, `T16CM_OFF_IRQ_STATUS) && avs_byteenable[0])
                    ? wdat[`T16CM_IRQ_W-1:0] : '0;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_status_reg <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   // output pins mirror any match output; several pins may share one
   generate
      for (gc = 0; gc < NP; gc++) begin : g_pin
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               match_pin[gc] <= 1'b0;
            end else begin
               match_pin[gc] <= ext_out_reg[out_route_reg[2*gc +: 2]]; // see RL11
            end
         end
      end
   endgenerate

   // read mux, sampled in the wait cycle so data stand when waitrequest drops
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hits(avs_address, `T16CM_OFF_CTRL)) begin
         rd_word = 32'(ctrl_reg);
      end else if (hits(avs_address, `T16CM_OFF_COUNT)) begin
         rd_word = 32'(count_reg);
      end else if (hits(avs_address, `T16CM_OFF_PRESCALE)) begin
         rd_word = 32'(prescale_reg);
      end else if (hits(avs_address, `T16CM_OFF_PRE_COUNT)) begin
         rd_word = 32'(pre_count_reg);
      end else if (hits(avs_address, `T16CM_OFF_MATCH_CTRL)) begin
         rd_word = 32'(match_ctrl_reg);
      end else if (hits(avs_address, `T16CM_OFF_MATCH0)) begin
         rd_word = 32'(match_reg[0]);
      end else if (hits(avs_address, `T16CM_OFF_MATCH0 + 8'h04)) begin
         rd_word = 32'(match_reg[1]);
      end else if (hits(avs_address, `T16CM_OFF_MATCH0 + 8'h08)) begin
         rd_word = 32'(match_reg[2]);
      end else if (hits(avs_address, `T16CM_OFF_MATCH0 + 8'h0c)) begin
         rd_word = 32'(match_reg[3]);
      end else if (hits(avs_address, `T16CM_OFF_CAP_CTRL)) begin
         rd_word = 32'(cap_ctrl_reg);
      end else if (hits(avs_address, `T16CM_OFF_CAP0)) begin
         rd_word = 32'(cap_reg[0]);
      end else if (hits(avs_address, `T16CM_OFF_CAP0 + 8'h04)) begin
         rd_word = 32'(cap_reg[1]);
      end else if (hits(avs_address, `T16CM_OFF_CAP0 + 8'h08)) begin
         rd_word = 32'(cap_reg[2]);
      end else if (hits(avs_address, `T16CM_OFF_OUT_CTRL)) begin
         rd_word = 32'(out_ctrl_reg);
      end else if (hits(avs_address, `T16CM_OFF_EXT_OUT)) begin
         rd_word = 32'(ext_out_reg);
      end else if (hits(avs_address, `T16CM_OFF_IRQ_STATUS)) begin
         rd_word = 32'(irq_status_reg);
      end else if (hits(avs_address, `T16CM_OFF_IRQ_MASK)) begin
         rd_word = 32'(irq_mask_reg);
      end else if (hits(avs_address, `T16CM_OFF_CAP_ROUTE)) begin
         rd_word = 32'(cap_route_reg);
      end else if (hits(avs_address, `T16CM_OFF_OUT_ROUTE)) begin
         rd_word = 32'(out_route_reg);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && bus_state_reg == T16CM_BUS_IDLE) begin
         avs_readdata <= rd_word;
      end
   end
endmodule

//--- testbench/t16cm_assertions.sv
// port assertions for the 16-bit timer block, bound to t16cm_top
// assumes one sys_clk domain and a synchronous active-low reset
`timescale 1ns/1ns
`include "t16cm_defines.svh"
module t16cm_assertions #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pins and interrupt
   input wire logic [`T16CM_NUM_PIN-1:0] cap_pin,
   input wire logic [`T16CM_NUM_PIN-1:0] match_pin,
   input wire logic irq
);
   logic [6:0] mask_reg;
   logic wr_done;
   logic rd_done;
   assign wr_done = avs_write && !avs_waitrequest;
   assign rd_done = avs_read && !avs_waitrequest;
   // mask shadow rebuilt from completed writes, lane 0 only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mask_reg <= 7'h00;
      end else if (wr_done && avs_byteenable[0]
                   && {avs_address[7:2], 2'b00} == `T16CM_OFF_IRQ_MASK) begin
         mask_reg <= avs_writedata[6:0];
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence fresh_req;
      $rose(avs_read || avs_write);
   endsequence
   sequence one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   wait_first_a: assert property (fresh_req |-> one_wait)
      else $error("bus answer not after one wait state");
   wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high without a request");
   ack_once_a: assert property ((avs_read || avs_write) && !avs_waitrequest
                                |=> !(avs_read || avs_write) || avs_waitrequest)
      else $error("bus answered twice in a row");
   rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   unmapped_rd_a: assert property (rd_done && avs_address >= 8'h4c |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   mask_rd_a: assert property (rd_done && {avs_address[7:2], 2'b00} == `T16CM_OFF_IRQ_MASK
                               |-> avs_readdata[6:0] == mask_reg)
      else $error("mask read differs from last write");
   irq_masked_a: assert property (mask_reg == 7'h00 |-> !irq)
      else $error("interrupt high while fully masked");
   rst_quiet_a: assert property ($rose(rst_n) |-> avs_readdata == 32'h0 && !irq && match_pin == '0)
      else $error("outputs not quiet after reset");
endmodule

bind t16cm_top t16cm_assertions #(.CNT_W(CNT_W)) u_t16cm_chk (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .cap_pin(cap_pin),
   .match_pin(match_pin),
   .irq(irq)
);

//--- testbench/t16cm_pins.sv
// model of the external event sources and match pin loads
// assumes the bench calls its tasks from a sys_clk-aligned process
`timescale 1ns/1ns
`include "t16cm_defines.svh"
module t16cm_pins (
   // clock
   input wire logic sys_clk,
   // pins toward the block
   output logic [`T16CM_NUM_PIN-1:0] cap_pin,
   input wire logic [`T16CM_NUM_PIN-1:0] match_pin
);
   initial cap_pin = '0;
   task automatic set_pin(input int p, input logic v);
      @(posedge sys_clk);
      cap_pin[p] <= v;
   endtask
   // each level held two clocks at least, or the input filter drops it
   task automatic pulse(input int p, input int hold);
      int h;
      h = (hold < 2) ? 2 : hold;
      set_pin(p, 1'b1);
      repeat (h) @(posedge sys_clk);
      cap_pin[p] <= 1'b0;
      repeat (h) @(posedge sys_clk);
   endtask
endmodule

//--- testbench/test_timer16_capture_match.sv
// self-checking bench for the 16-bit timer block
// assumes t16cm_top, the pin model t16cm_pins and the bound checker
`timescale 1ns/1ns
`include "t16cm_defines.svh"
module test_timer16_capture_match;
   import t16cm_pkg::*;
   typedef struct {
      logic [31:0] val;
      logic [31:0] msk;
   } t16cm_exp_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] cap_pin;
   logic [3:0] match_pin;
   logic irq;
   t16cm_exp_t exp_q[$];
   t16cm_exp_t e;
   int mismatches = 0;
   int comparisons = 0;
   int k;
   logic pre;
   logic want;

   always #50 sys_clk = ~sys_clk;

   t16cm_top #(.CNT_W(16)) DUT (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .cap_pin(cap_pin),
      .match_pin(match_pin),
      .irq(irq)
   );
   t16cm_pins PIN (.sys_clk(sys_clk), .cap_pin(cap_pin), .match_pin(match_pin));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         final_report();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   // the watcher below compares once the answer edge comes
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      exp_q.push_back('{v, m});
      bus(1'b0, a, 32'h0);
   endtask

   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      if (irq !== 1'b1) begin
         mismatches++;
         final_report();
      end
   endtask

   task automatic chk_irq(input logic v);
      @(negedge sys_clk);
      check({31'h0, irq}, {31'h0, v});
   endtask

   always @(posedge sys_clk) begin
      if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check(avs_readdata & e.msk, e.val);
      end
   end

   initial begin
      void'($urandom(37));
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      wr(8'h4c, 32'hffffffff);
      rd(`T16CM_OFF_CTRL, 32'h0, '1);
      rd(`T16CM_OFF_MATCH0, 32'h0, '1);
      rd(`T16CM_OFF_IRQ_MASK, 32'h0, '1);
      rd(`T16CM_OFF_CAP_ROUTE, {8'h00, `T16CM_RST_CAP_ROUTE}, '1);
      rd(`T16CM_OFF_OUT_ROUTE, {24'h0, `T16CM_RST_OUT_ROUTE}, '1);
      rd(8'h4c, 32'h0, '1);
      wr(`T16CM_OFF_IRQ_MASK, 32'h7f);
      wr(`T16CM_OFF_PRESCALE, $urandom_range(2, 0));
      // every pin mirrors channel 0
      wr(`T16CM_OFF_OUT_ROUTE, 32'h0);
      wr(`T16CM_OFF_MATCH0, 32'h3);
      wr(`T16CM_OFF_MATCH_CTRL, 32'h7);
      for (int act = 0; act < 4; act++) begin
         pre = 1'($urandom_range(1, 0));
         wr(`T16CM_OFF_EXT_OUT, {28'h0, {4{pre}}});
         wr(`T16CM_OFF_OUT_CTRL, 32'(act));
         wr(`T16CM_OFF_IRQ_STATUS, 32'h7f);
         wr(`T16CM_OFF_CTRL, 32'h1);
         wait_irq(60);
         repeat (2) @(negedge sys_clk);
         want = (act == 1) ? 1'b0 : (act == 2) ? 1'b1 : (act == 3) ? !pre : pre;
         check({28'h0, match_pin}, {28'h0, {4{want}}});
         rd(`T16CM_OFF_COUNT, 32'h0, '1);
         rd(`T16CM_OFF_CTRL, 32'h0, 32'h1);
      end
      wr(`T16CM_OFF_MATCH_CTRL, 32'h5);
      wr(`T16CM_OFF_IRQ_STATUS, 32'h7f);
      wr(`T16CM_OFF_CTRL, 32'h1);
      wait_irq(60);
      rd(`T16CM_OFF_COUNT, 32'h3, '1);
      rd(`T16CM_OFF_CTRL, 32'h0, 32'h1);
      // event counting on pin 0, prescale of two events per step
      wr(`T16CM_OFF_MATCH_CTRL, 32'h0);
      wr(`T16CM_OFF_PRESCALE, 32'h1);
      wr(`T16CM_OFF_COUNT, 32'h0);
      wr(`T16CM_OFF_CAP_CTRL, 32'h168);
      wr(`T16CM_OFF_CAP_ROUTE, 32'h008c0201);
      wr(`T16CM_OFF_IRQ_STATUS, 32'h7f);
      wr(`T16CM_OFF_CTRL, {26'h0, 2'd0, T16CM_MODE_RISE, 1'b0, 1'b1});
      k = $urandom_range(8, 3);
      repeat (k) PIN.pulse(0, 2 + $urandom_range(1, 0));
      repeat (8) @(posedge sys_clk);
      rd(`T16CM_OFF_COUNT, k >> 1, '1);
      rd(`T16CM_OFF_PRE_COUNT, k & 1, '1);
      PIN.pulse(1, 3);
      repeat (8) @(posedge sys_clk);
      rd(`T16CM_OFF_CAP0 + 8'h04, k >> 1, '1);
      rd(`T16CM_OFF_IRQ_STATUS, 32'h20, 32'h7f);
      chk_irq(1'b1);
      wr(`T16CM_OFF_IRQ_MASK, 32'h0);
      chk_irq(1'b0);
      wr(`T16CM_OFF_IRQ_MASK, 32'h7f);
      wr(`T16CM_OFF_IRQ_STATUS, 32'h20);
      chk_irq(1'b0);
      // channel 2 needs pins 2 and 3 high together
      PIN.pulse(2, 3);
      repeat (8) @(posedge sys_clk);
      rd(`T16CM_OFF_IRQ_STATUS, 32'h0, 32'h7f);
      PIN.set_pin(3, 1'b1);
      PIN.pulse(2, 3);
      repeat (8) @(posedge sys_clk);
      rd(`T16CM_OFF_CAP0 + 8'h08, k >> 1, '1);
      rd(`T16CM_OFF_IRQ_STATUS, 32'h40, 32'h7f);
      PIN.set_pin(3, 1'b0);
      wr(`T16CM_OFF_CTRL, 32'hd);
      PIN.pulse(0, 2);
      repeat (8) @(posedge sys_clk);
      rd(`T16CM_OFF_COUNT, (k >> 1) + 1, '1);
      // continuous match at the top of the range, then wrap
      wr(`T16CM_OFF_CTRL, 32'h2);
      wr(`T16CM_OFF_CTRL, 32'h0);
      wr(`T16CM_OFF_PRESCALE, 32'h0);
      wr(`T16CM_OFF_MATCH0 + 8'h08, 32'hffff);
      wr(`T16CM_OFF_MATCH_CTRL, 32'h40);
      wr(`T16CM_OFF_IRQ_STATUS, 32'h7f);
      wr(`T16CM_OFF_COUNT, 32'hfffd);
      wr(`T16CM_OFF_CTRL, 32'h1);
      wait_irq(40);
      rd(`T16CM_OFF_COUNT, 32'h0, 32'hfffffff0);
      rd(`T16CM_OFF_IRQ_STATUS, 32'h04, 32'h7f);
      repeat (4) @(posedge sys_clk);
      final_report();
   end

   initial begin
      #5000000;
      mismatches++;
      final_report();
   end
endmodule
